// [hw/rse_pkg.sv]
package rse_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int INSTR_W = 14;
  localparam int NIB_W = 4;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int OP6_LSB = 8;
  localparam int OP5_LSB = 9;
  localparam int DEST_BIT = 7;
  localparam int ADDR_LSB = 0;
  localparam int LIT_LSB = 0;
  localparam logic [5:0] ROT_CODE = 6'h0c;
  localparam logic [5:0] FSUB_CODE = 6'h02;
  localparam logic [4:0] LSUB_CODE = 5'h1e;
  localparam logic DEST_WORK = 1'h0;
  localparam logic DEST_FILE = 1'h1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    no_op,
    rotate_right_carry_op,
    literal_minus_work_op,
    file_minus_work_op
  } op_type;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } flags_type;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_wr_type;

  typedef struct packed {
    logic [DATA_W-1:0] work;
    flags_type flags;
    file_wr_type file_wr;
    logic done;
    logic unknown;
  } exec_state_type;

endpackage : rse_pkg

// [hw/sub_flags_unit.sv]
`timescale 1ns/1ps

module sub_flags_unit #(
  parameter int WIDTH = rse_pkg::DATA_W
) (
  input wire logic [WIDTH-1:0] minuend_in,     // Left operand
  input wire logic [WIDTH-1:0] subtrahend_in,  // Working register
  output logic [WIDTH-1:0] diff_out,           // Low bits of difference
  output rse_pkg::flags_type flags_out         // Carry, digit carry, zero
);

  logic [WIDTH:0] full_diff;
  logic [rse_pkg::NIB_W:0] nib_diff;

  // ----------------------------------------------------------------
  // Two's complement subtract; top bit is the borrow
  // ----------------------------------------------------------------
  always_comb begin
    full_diff = {1'b0, minuend_in} - {1'b0, subtrahend_in};
    nib_diff = {1'b0, minuend_in[rse_pkg::NIB_W-1:0]}
             - {1'b0, subtrahend_in[rse_pkg::NIB_W-1:0]};
    diff_out = full_diff[WIDTH-1:0];
    flags_out.carry = ~full_diff[WIDTH];
    flags_out.digit_carry_flag = ~nib_diff[rse_pkg::NIB_W];
    flags_out.zero = (full_diff[WIDTH-1:0] == '0);
  end

endmodule : sub_flags_unit

// [hw/rotate_subtract_exec.sv]
`timescale 1ns/1ps

module rotate_subtract_exec (
  input wire logic clk_in,                                    // 25 MHz clock
  input wire logic nrst_in,                                   // Sync reset
  input wire logic instr_valid_in,                            // Execute now
  input wire logic [rse_pkg::INSTR_W-1:0] instr_in,           // Opcode word
  input wire logic [rse_pkg::DATA_W-1:0] file_data_in,        // Addressed reg
  output logic [rse_pkg::DATA_W-1:0] work_out,                // Working reg
  output logic carry_out,                                     // Carry flag
  output logic digit_carry_out,                               // Digit carry
  output logic zero_out,                                      // Zero flag
  output logic file_we_out,                                   // File write
  output logic [rse_pkg::ADDR_W-1:0] file_addr_out,           // Write address
  output logic [rse_pkg::DATA_W-1:0] file_wdata_out,          // Write data
  output logic done_out,                                      // Completed op
  output logic unknown_op_out                                 // Not handled
);

  rse_pkg::exec_state_type state;
  rse_pkg::exec_state_type next_state;
  rse_pkg::op_type op;
  logic dest;
  logic [rse_pkg::ADDR_W-1:0] addr;
  logic [rse_pkg::DATA_W-1:0] literal;
  logic [rse_pkg::DATA_W-1:0] sub_a;
  logic [rse_pkg::DATA_W-1:0] sub_diff;
  rse_pkg::flags_type sub_flags;
  logic [rse_pkg::DATA_W-1:0] rot_result;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    dest = instr_in[rse_pkg::DEST_BIT];
    addr = instr_in[rse_pkg::ADDR_LSB +: rse_pkg::ADDR_W];
    literal = instr_in[rse_pkg::LIT_LSB +: rse_pkg::DATA_W];
    if (!instr_valid_in) begin
      op = rse_pkg::no_op;
    end else if (instr_in[rse_pkg::INSTR_W-1:rse_pkg::OP6_LSB]
                 == rse_pkg::ROT_CODE) begin
      op = rse_pkg::rotate_right_carry_op;
    end else if (instr_in[rse_pkg::INSTR_W-1:rse_pkg::OP6_LSB]
                 == rse_pkg::FSUB_CODE) begin
      op = rse_pkg::file_minus_work_op;
    end else if (instr_in[rse_pkg::INSTR_W-1:rse_pkg::OP5_LSB]
                 == rse_pkg::LSUB_CODE) begin
      op = rse_pkg::literal_minus_work_op;
    end else begin
      op = rse_pkg::no_op;
    end
    sub_a = (op == rse_pkg::literal_minus_work_op) ? literal
                                                    : file_data_in;
    rot_result = {state.flags.carry,
                  file_data_in[rse_pkg::DATA_W-1:1]};
  end

  // ----------------------------------------------------------------
  // Subtractor
  // ----------------------------------------------------------------
  sub_flags_unit #(
    .WIDTH(rse_pkg::DATA_W)
  ) sub_flags_unit_inst (
    .minuend_in(sub_a),
    .subtrahend_in(state.work),
    .diff_out(sub_diff),
    .flags_out(sub_flags)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.file_wr.we = 1'b0;
    next_state.done = 1'b0;
    next_state.unknown = instr_valid_in && (op == rse_pkg::no_op);
    unique case (op)
      rse_pkg::no_op: begin
      end
      rse_pkg::rotate_right_carry_op: begin
        next_state.done = 1'b1;
        next_state.flags.carry = file_data_in[0];
        if (dest == rse_pkg::DEST_WORK) begin
          next_state.work = rot_result;
        end else begin
          next_state.file_wr = '{1'b1, addr, rot_result};
        end
      end
      rse_pkg::literal_minus_work_op: begin
        next_state.done = 1'b1;
        next_state.work = sub_diff;
        next_state.flags = sub_flags;
      end
      rse_pkg::file_minus_work_op: begin
        next_state.done = 1'b1;
        next_state.flags = sub_flags;
        if (dest == rse_pkg::DEST_WORK) begin
          next_state.work = sub_diff;
        end else begin
          next_state.file_wr = '{1'b1, addr, sub_diff};
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state.work <= rse_pkg::WORK_RESET;
      state.flags <= '0;
      state.file_wr <= '{1'b0, rse_pkg::ADDR_RESET, rse_pkg::DATA_ZERO};
      state.done <= 1'b0;
      state.unknown <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign work_out = state.work;
  assign carry_out = state.flags.carry;
  assign digit_carry_out = state.flags.digit_carry_flag;
  assign zero_out = state.flags.zero;
  assign file_we_out = state.file_wr.we;
  assign file_addr_out = state.file_wr.addr;
  assign file_wdata_out = state.file_wr.data;
  assign done_out = state.done;
  assign unknown_op_out = state.unknown;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic is_rot;
  logic is_sub;
  logic is_fsub;
  logic [rse_pkg::DATA_W-1:0] exp_diff;
  logic [rse_pkg::NIB_W-1:0] a_nib;
  logic [rse_pkg::NIB_W-1:0] w_nib;

  always_comb begin
    is_rot = (op == rse_pkg::rotate_right_carry_op);
    is_fsub = (op == rse_pkg::file_minus_work_op);
    is_sub = is_fsub || (op == rse_pkg::literal_minus_work_op);
    exp_diff = sub_a - state.work;
    a_nib = sub_a[rse_pkg::NIB_W-1:0];
    w_nib = state.work[rse_pkg::NIB_W-1:0];
  end

  a_rot_work: assert property (
    is_rot && !dest |=> !file_we_out && work_out
      == {$past(carry_out), $past(file_data_in[rse_pkg::DATA_W-1:1])})
    else $error("rotate result wrong in working register");

  a_rot_carry: assert property (
    is_rot ##1 1'b1 |-> carry_out == $past(file_data_in[0]))
    else $error("rotate carry out wrong");

  a_rot_file: assert property (
    is_rot && dest |=> file_we_out
      && file_addr_out == $past(instr_in[rse_pkg::ADDR_LSB +: rse_pkg::ADDR_W])
      && file_wdata_out == {$past(carry_out),
      $past(file_data_in[rse_pkg::DATA_W-1:1])} && $stable(work_out))
    else $error("rotate write back wrong");

  a_rot_decode: assert property (
    instr_valid_in && instr_in[rse_pkg::INSTR_W-1:rse_pkg::OP6_LSB]
      == rse_pkg::ROT_CODE |=> done_out && !unknown_op_out)
    else $error("rotate opcode not executed");

  a_lit_sub: assert property (
    op == rse_pkg::literal_minus_work_op
      |=> work_out == $past(literal) - $past(work_out) && !file_we_out)
    else $error("literal subtract result wrong");

  a_carry_set: assert property (
    is_sub && sub_a >= state.work |=> carry_out)
    else $error("carry not set without borrow");

  a_carry_clear: assert property (
    is_sub && sub_a < state.work |=> !carry_out)
    else $error("carry not cleared on borrow");

  a_file_sub: assert property (
    is_fsub && dest |=> file_we_out
      && file_wdata_out == $past(file_data_in) - $past(work_out)
      && $stable(work_out))
    else $error("file subtract write back wrong");

  a_file_sub_work: assert property (
    is_fsub && !dest |=> !file_we_out
      && work_out == $past(file_data_in) - $past(work_out))
    else $error("file subtract to working register wrong");

  a_rot_flags_kept: assert property (
    is_rot |=> $stable(zero_out) && $stable(digit_carry_out))
    else $error("rotate altered zero or digit carry");

  a_sub_zero_dc: assert property (
    is_sub |=> zero_out == ($past(exp_diff) == 8'h00)
      && digit_carry_out == ($past(a_nib) >= $past(w_nib)))
    else $error("subtract zero or digit carry wrong");

  a_one_cycle: assert property (
    op != rse_pkg::no_op |=> done_out && !unknown_op_out)
    else $error("instruction did not complete in one cycle");

  a_idle_quiet: assert property (
    !instr_valid_in |=> !done_out && !unknown_op_out && !file_we_out
      && $stable(work_out))
    else $error("idle cycle changed results");

  c_rot_file: cover property (is_rot && dest ##1 file_we_out);
  c_sub_borrow: cover property (is_sub && sub_a < state.work);
  c_sub_zero: cover property (is_sub ##1 zero_out);
  c_back_to_back: cover property (is_sub ##1 is_rot);

endmodule : rotate_subtract_exec

// [sim/rotate_subtract_exec_tb_top.sv]
`timescale 1ns/1ps

module rotate_subtract_exec_tb_top;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic instr_valid_in = 1'b0;
  logic [13:0] instr_in = 14'h0000;
  logic [7:0] file_data_in = 8'h00;
  logic [7:0] work_out;
  logic [7:0] file_wdata_out;
  logic [6:0] file_addr_out;
  logic carry_out, digit_carry_out, zero_out;
  logic file_we_out, done_out, unknown_op_out;
  logic [7:0] e_w, e_wd;
  logic [6:0] e_ad;
  logic e_c, e_dc, e_z, e_we, e_dn, e_un;
  int mismatches = 0;
  int n_tests = 0;

  always #20 clk_in = ~clk_in;

  rotate_subtract_exec rotate_subtract_exec_inst (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .instr_valid_in(instr_valid_in),
    .instr_in(instr_in),
    .file_data_in(file_data_in),
    .work_out(work_out),
    .carry_out(carry_out),
    .digit_carry_out(digit_carry_out),
    .zero_out(zero_out),
    .file_we_out(file_we_out),
    .file_addr_out(file_addr_out),
    .file_wdata_out(file_wdata_out),
    .done_out(done_out),
    .unknown_op_out(unknown_op_out)
  );

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // --------------------------------------------------------------
  // Compare every output against the bench model
  // --------------------------------------------------------------
  task check_all;
    chk("work", e_w, work_out);
    chk("carry", {7'h00, e_c}, {7'h00, carry_out});
    chk("dcarry", {7'h00, e_dc}, {7'h00, digit_carry_out});
    chk("zero", {7'h00, e_z}, {7'h00, zero_out});
    chk("we", {7'h00, e_we}, {7'h00, file_we_out});
    chk("addr", {1'b0, e_ad}, {1'b0, file_addr_out});
    chk("wdata", e_wd, file_wdata_out);
    chk("done", {7'h00, e_dn}, {7'h00, done_out});
    chk("unknown", {7'h00, e_un}, {7'h00, unknown_op_out});
  endtask : check_all

  // Checks the previous word, then presents the next one
  task issue(input logic v, input logic [13:0] ins, input logic [7:0] fd);
    logic [8:0] d;
    logic [4:0] n;
    logic [7:0] r;
    logic [7:0] a;
    logic lit;
    @(posedge clk_in);
    #1;
    check_all();
    instr_valid_in = v;
    instr_in = ins;
    file_data_in = fd;
    e_we = 1'b0;
    e_dn = v;
    e_un = 1'b0;
    lit = (ins[13:9] == rse_pkg::LSUB_CODE);
    if (!v) return;
    if (ins[13:8] == rse_pkg::ROT_CODE) begin
      r = {e_c, fd[7:1]};
      e_c = fd[0];
    end else if (ins[13:8] == rse_pkg::FSUB_CODE || lit) begin
      a = lit ? ins[7:0] : fd;
      d = {1'b0, a} - {1'b0, e_w};
      n = {1'b0, a[3:0]} - {1'b0, e_w[3:0]};
      r = d[7:0];
      e_c = ~d[8];
      e_dc = ~n[4];
      e_z = (r == 8'h00);
    end else begin
      e_dn = 1'b0;
      e_un = 1'b1;
      return;
    end
    if (lit || ins[7] == rse_pkg::DEST_WORK) begin
      e_w = r;
    end else begin
      e_we = 1'b1;
      e_ad = ins[6:0];
      e_wd = r;
    end
  endtask : issue

  task do_reset(input int n);
    @(posedge clk_in);
    #1;
    nrst_in = 1'b0;
    instr_valid_in = 1'b0;
    repeat (n) @(posedge clk_in);
    #1;
    {e_w, e_wd, e_ad, e_c, e_dc, e_z, e_we, e_dn, e_un} = '0;
    check_all();
    nrst_in = 1'b1;
  endtask : do_reset

  task summarize;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    do_reset(10);
    $display("Test reset done");
    issue(1'b1, 14'h3c01, 8'h00);
    issue(1'b1, 14'h3c02, 8'h00);
    issue(1'b1, 14'h3c01, 8'h00);
    issue(1'b1, 14'h3d03, 8'h00);
    issue(1'b1, 14'h3c02, 8'h00);
    issue(1'b1, 14'h3c01, 8'h00);
    $display("Test literal subtract done");
    issue(1'b1, 14'h0283, 8'h03);
    issue(1'b1, 14'h0283, 8'h02);
    issue(1'b1, 14'h0283, 8'h01);
    issue(1'b1, 14'h02ff, 8'h13);
    issue(1'b1, 14'h0203, 8'h37);
    $display("Test file subtract done");
    issue(1'b1, 14'h0c09, 8'he6);
    issue(1'b1, 14'h0c89, 8'he6);
    issue(1'b1, 14'h0c89, 8'h01);
    issue(1'b1, 14'h0cc9, 8'h00);
    $display("Test rotate done");
    issue(1'b1, 14'h0d00, 8'h55);
    issue(1'b1, 14'h0e12, 8'h55);
    issue(1'b1, 14'h3a00, 8'h55);
    issue(1'b1, 14'h0302, 8'h55);
    issue(1'b0, 14'h0000, 8'h00);
    issue(1'b0, 14'h0000, 8'h00);
    $display("Test unknown words done");
    do_reset(1);
    issue(1'b1, 14'h3c05, 8'h00);
    issue(1'b1, 14'h0c80, 8'h01);
    issue(1'b0, 14'h0000, 8'h00);
    issue(1'b0, 14'h0000, 8'h00);
    $display("Test mid run reset done");
    summarize();
  end
endmodule : rotate_subtract_exec_tb_top
